// ### eprom_write_defines.svh
// constants for the eprom write command sequencer
// assumes the includers use these names in design logic and in the bench
`ifndef EPROM_WRITE_DEFINES_SVH
`define EPROM_WRITE_DEFINES_SVH

// ----------------------------------------------------------------
// memory function command codes
// ----------------------------------------------------------------
`define CMD_WRITE_DATA   8'h0F
`define CMD_SPEED_DATA   8'hF3
`define CMD_WRITE_STAT   8'h55
`define CMD_SPEED_STAT   8'hF5

// ----------------------------------------------------------------
// crc, address and fill values
// ----------------------------------------------------------------
`define CRC_POLY_REFL    16'hA001
`define CRC_CLEAR        16'h0000
`define ADDR_KEEP_MASK   16'h07FF
`define ADDR_STEP        16'h0001
`define ERASED_BYTE      8'hFF
`define ONES_BYTE        8'hFF
`define BYTE_BITS        8

`endif

// ### eprom_write_pkg.sv
// shared types of the eprom write command sequencer
// assumes nothing beyond a systemverilog compiler
package eprom_write_pkg;

    // ----------------------------------------------------------------
    // sequencer states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [10:0] {
        ST_IDLE   = 11'b000_0000_0001,
        ST_ADR_LO = 11'b000_0000_0010,
        ST_ADR_HI = 11'b000_0000_0100,
        ST_DATA   = 11'b000_0000_1000,
        ST_CRC_LO = 11'b000_0001_0000,
        ST_CRC_HI = 11'b000_0010_0000,
        ST_WAIT   = 11'b000_0100_0000,
        ST_VERIFY = 11'b000_1000_0000,
        ST_VDRAIN = 11'b001_0000_0000,
        ST_TAIL   = 11'b010_0000_0000,
        ST_PASS   = 11'b100_0000_0000
    } seq_state_t;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic status;   // target the status field
        logic speed;    // no crc before the programming pulse
    } write_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } write_target_t;

endpackage

// ### byte_skid_buffer.sv
// two-entry buffer with valid and ready on both sides
// assumes a single clock and a synchronous active-high reset
module byte_skid_buffer #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  empty
);

    logic             out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    logic             skid_valid_q;
    logic [WIDTH-1:0] skid_data_q;
    logic             in_fire;

    if (WIDTH < 1)
    begin : g_chk
        $error("byte_skid_buffer: WIDTH must be at least one");
    end

    // ready depends only on a flop, so no combinational path reaches the source
    assign in_ready  = ~skid_valid_q;
    assign in_fire   = in_valid & ~skid_valid_q;
    assign out_valid = out_valid_q;
    assign out_data  = out_data_q;
    assign empty     = ~out_valid_q & ~skid_valid_q;

    always_ff @(posedge clk_sys)
    begin
        if (rst || flush)
        begin
            out_valid_q  <= 1'b0;
            skid_valid_q <= 1'b0;
        end
        else if (!out_valid_q || out_ready)
        begin
            if (skid_valid_q)
            begin
                out_valid_q  <= 1'b1;
                skid_valid_q <= 1'b0;
            end
            else
            begin
                out_valid_q <= in_fire;
            end
        end
        else if (in_fire)
        begin
            skid_valid_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            out_data_q  <= '0;
            skid_data_q <= '0;
        end
        else if (!out_valid_q || out_ready)
        begin
            if (skid_valid_q)
                out_data_q <= skid_data_q;
            else if (in_fire)
                out_data_q <= in_data;
        end
        else if (in_fire)
        begin
            skid_data_q <= in_data;
        end
    end

endmodule

// ### eprom_write_command_sequencer.sv
// eprom write command sequencer: data and status writes, speed variants,
// crc echo, programming, verify and auto-increment, extended read tail.
// assumes a slot layer outside that turns master slots into bytes (lsb
// first), flags the end of each programming pulse and each reset pulse.
`include "eprom_write_defines.svh"

module eprom_write_command_sequencer #(
    parameter int DATA_BYTES   = 2048,
    parameter int STATUS_BYTES = 64
) (
    input  wire logic  clk_sys,
    input  wire logic  rst,
    input  wire logic  bus_reset,
    input  wire logic  ext_read_done,
    input  wire logic  prog_pulse,
    input  wire logic  rx_valid,
    input  wire logic [7:0] rx_byte,
    output logic       rx_ready,
    output logic       tx_valid,
    input  wire logic  tx_ready,
    output logic [7:0] tx_byte,
    output logic       prog_armed,
    output logic       busy
);

    localparam int DW = $clog2(DATA_BYTES);
    localparam int SW = $clog2(STATUS_BYTES);

    if (DATA_BYTES != (1 << DW) || DATA_BYTES > 2048 || STATUS_BYTES != (1 << SW)
        || STATUS_BYTES > DATA_BYTES || SW < 1)
    begin : g_chk
        $error("sequencer: field sizes must be powers of two, status within data");
    end

    eprom_write_pkg::seq_state_t    state_q;
    eprom_write_pkg::seq_state_t    state_d;
    eprom_write_pkg::write_mode_t   mode_q;
    eprom_write_pkg::write_target_t tgt_q;
    logic [15:0] crc_q;
    logic        rx_ready_q;
    logic        prog_armed_q;
    logic        busy_q;
    logic        rx_take;
    logic        buf_in_valid;
    logic        buf_in_ready;
    logic [7:0]  buf_in_data;
    logic        buf_empty;
    logic        push;
    logic [7:0]  mem_rd;
    logic [7:0]  hi_masked;
    logic [15:0] addr_next;

    logic [7:0] data_mem [DATA_BYTES];
    logic [7:0] stat_mem [STATUS_BYTES];

    // ----------------------------------------------------------------
    // crc engine
    // ----------------------------------------------------------------
    function automatic logic [15:0] crc_shift(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc;
        for (int i = 0; i < `BYTE_BITS; i++)
        begin
            if (c[0] ^ b[i])
                c = (c >> 1) ^ `CRC_POLY_REFL;
            else
                c = c >> 1;
        end
        return c;
    endfunction

    assign rx_take   = rx_valid & rx_ready_q;
    assign push      = buf_in_valid & buf_in_ready;
    // only the high byte of the keep mask applies to the high address byte
    assign hi_masked = rx_byte & 8'(`ADDR_KEEP_MASK >> `BYTE_BITS);
    assign addr_next = (tgt_q.addr + `ADDR_STEP) & `ADDR_KEEP_MASK;
    assign mem_rd    = mode_q.status ? stat_mem[tgt_q.addr[SW-1:0]]
                                     : data_mem[tgt_q.addr[DW-1:0]];

    // ----------------------------------------------------------------
    // sequence control
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            eprom_write_pkg::ST_IDLE:
                if (rx_take)
                begin
                    unique case (rx_byte)
                        `CMD_WRITE_DATA, `CMD_SPEED_DATA,
                        `CMD_WRITE_STAT, `CMD_SPEED_STAT: state_d = eprom_write_pkg::ST_ADR_LO;
                        default:                          state_d = eprom_write_pkg::ST_PASS;
                    endcase
                end
            eprom_write_pkg::ST_ADR_LO:
                if (rx_take) state_d = eprom_write_pkg::ST_ADR_HI;
            eprom_write_pkg::ST_ADR_HI:
                if (rx_take) state_d = eprom_write_pkg::ST_DATA;
            eprom_write_pkg::ST_DATA:
                if (rx_take)
                    state_d = mode_q.speed ? eprom_write_pkg::ST_WAIT
                                           : eprom_write_pkg::ST_CRC_LO;
            eprom_write_pkg::ST_CRC_LO:
                if (push) state_d = eprom_write_pkg::ST_CRC_HI;
            eprom_write_pkg::ST_CRC_HI:
                if (push) state_d = eprom_write_pkg::ST_WAIT;
            eprom_write_pkg::ST_WAIT:
                if (prog_pulse) state_d = eprom_write_pkg::ST_VERIFY;
            eprom_write_pkg::ST_VERIFY:
                if (push) state_d = eprom_write_pkg::ST_VDRAIN;
            eprom_write_pkg::ST_VDRAIN:
                if (buf_empty) state_d = eprom_write_pkg::ST_DATA;
            eprom_write_pkg::ST_TAIL:
                state_d = eprom_write_pkg::ST_TAIL;
            eprom_write_pkg::ST_PASS:
                if (ext_read_done) state_d = eprom_write_pkg::ST_TAIL;
        endcase
        if (bus_reset)
            state_d = eprom_write_pkg::ST_IDLE;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state_q <= eprom_write_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    // ready and status outputs are registered from the next state
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rx_ready_q   <= 1'b0;
            prog_armed_q <= 1'b0;
            busy_q       <= 1'b0;
        end
        else
        begin
            rx_ready_q   <= state_d inside {eprom_write_pkg::ST_IDLE, eprom_write_pkg::ST_ADR_LO,
                                            eprom_write_pkg::ST_ADR_HI, eprom_write_pkg::ST_DATA};
            prog_armed_q <= state_d == eprom_write_pkg::ST_WAIT;
            busy_q       <= state_d != eprom_write_pkg::ST_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // mode, address, data and crc
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst || bus_reset)
            mode_q <= '0;
        else if (state_q == eprom_write_pkg::ST_IDLE && rx_take)
        begin
            mode_q.status <= rx_byte == `CMD_WRITE_STAT || rx_byte == `CMD_SPEED_STAT;
            mode_q.speed  <= rx_byte == `CMD_SPEED_DATA || rx_byte == `CMD_SPEED_STAT;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || bus_reset)
            tgt_q <= '0;
        else if (state_q == eprom_write_pkg::ST_ADR_LO && rx_take)
            tgt_q.addr[7:0] <= rx_byte;
        else if (state_q == eprom_write_pkg::ST_ADR_HI && rx_take)
            tgt_q.addr[15:8] <= hi_masked;
        else if (state_q == eprom_write_pkg::ST_DATA && rx_take)
            tgt_q.data <= rx_byte;
        else if (state_q == eprom_write_pkg::ST_VDRAIN && buf_empty)
            tgt_q.addr <= addr_next;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || bus_reset)
            crc_q <= `CRC_CLEAR;
        else if (rx_take && state_q == eprom_write_pkg::ST_IDLE)
            crc_q <= crc_shift(`CRC_CLEAR, rx_byte);
        else if (rx_take && state_q == eprom_write_pkg::ST_ADR_HI)
            crc_q <= crc_shift(crc_q, hi_masked);
        else if (rx_take && (state_q == eprom_write_pkg::ST_ADR_LO
                             || state_q == eprom_write_pkg::ST_DATA))
            crc_q <= crc_shift(crc_q, rx_byte);
        else if (state_q == eprom_write_pkg::ST_VDRAIN && buf_empty)
            crc_q <= addr_next;
    end

    // ----------------------------------------------------------------
    // eprom arrays
    // ----------------------------------------------------------------
    // the erase on rst stands for a blank part; a bus reset keeps contents
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            for (int i = 0; i < DATA_BYTES; i++)
                data_mem[i] <= `ERASED_BYTE;
            for (int i = 0; i < STATUS_BYTES; i++)
                stat_mem[i] <= `ERASED_BYTE;
        end
        else if (state_q == eprom_write_pkg::ST_WAIT && prog_pulse && !bus_reset)
        begin
            if (mode_q.status)
                stat_mem[tgt_q.addr[SW-1:0]] <= mem_rd & tgt_q.data;
            else
                data_mem[tgt_q.addr[DW-1:0]] <= mem_rd & tgt_q.data;
        end
    end

    // ----------------------------------------------------------------
    // answers to read slots
    // ----------------------------------------------------------------
    always_comb
    begin
        buf_in_valid = 1'b1;
        buf_in_data  = `ONES_BYTE;
        unique case (state_q)
            eprom_write_pkg::ST_CRC_LO: buf_in_data = ~crc_q[7:0];
            eprom_write_pkg::ST_CRC_HI: buf_in_data = ~crc_q[15:8];
            eprom_write_pkg::ST_VERIFY: buf_in_data = mem_rd;
            eprom_write_pkg::ST_TAIL:   buf_in_data = `ONES_BYTE;
            default:                    buf_in_valid = 1'b0;
        endcase
    end

    byte_skid_buffer #(
        .WIDTH (`BYTE_BITS)
    ) u_tx_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .flush     (bus_reset),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_byte),
        .empty     (buf_empty)
    );

    assign rx_ready   = rx_ready_q;
    assign prog_armed = prog_armed_q;
    assign busy       = busy_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    cmd_order_a: assert property (
        state_q == eprom_write_pkg::ST_ADR_LO && rx_take && !bus_reset
        ##1 rx_take && !bus_reset |=> state_q == eprom_write_pkg::ST_DATA)
        else $error("address bytes not followed by data phase");

    crc_echo_a: assert property (
        state_q == eprom_write_pkg::ST_DATA && rx_take && !mode_q.speed && !bus_reset
        |=> state_q == eprom_write_pkg::ST_CRC_LO && buf_in_data == ~crc_q[7:0])
        else $error("crc not offered after data byte");

    addr_trunc_a: assert property (
        (tgt_q.addr & ~`ADDR_KEEP_MASK) == `CRC_CLEAR)
        else $error("address above top byte location");

    program_and_a: assert property (
        state_q == eprom_write_pkg::ST_WAIT && prog_pulse && !bus_reset
        |=> mem_rd == ($past(mem_rd) & $past(tgt_q.data))
            && state_q == eprom_write_pkg::ST_VERIFY && buf_in_data == mem_rd)
        else $error("programmed byte is not the and of old and new");

    incr_seed_a: assert property (
        state_q == eprom_write_pkg::ST_VDRAIN && buf_empty && !bus_reset
        |=> tgt_q.addr == (($past(tgt_q.addr) + `ADDR_STEP) & `ADDR_KEEP_MASK)
            && crc_q == tgt_q.addr && state_q == eprom_write_pkg::ST_DATA)
        else $error("address not stepped or crc not seeded");

    abort_seq_a: assert property (
        bus_reset |=> state_q == eprom_write_pkg::ST_IDLE && !tx_valid && !prog_armed)
        else $error("reset pulse did not abort the sequence");

    speed_skip_a: assert property (
        state_q == eprom_write_pkg::ST_DATA && rx_take && mode_q.speed && !bus_reset
        |=> state_q == eprom_write_pkg::ST_WAIT && prog_armed)
        else $error("speed write did not skip the crc");

    status_cmd_a: assert property (
        state_q == eprom_write_pkg::ST_IDLE && rx_take && rx_byte == `CMD_SPEED_STAT && !bus_reset
        |=> mode_q.status && mode_q.speed && state_q == eprom_write_pkg::ST_ADR_LO)
        else $error("speed status write not recognised");

    tail_ones_a: assert property (
        state_q == eprom_write_pkg::ST_PASS && ext_read_done && !bus_reset
        |=> state_q == eprom_write_pkg::ST_TAIL ##[1:3] tx_valid && tx_byte == `ONES_BYTE)
        else $error("no ones after final page crc");

endmodule

// ### slot_master_model.sv
// bus master stand-in: hands written bytes in, collects read bytes
// assumes the bench steps stall and calls send_byte from one thread
module slot_master_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       stall,
    input  wire logic       rx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] got_q [$];

    initial
    begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
    end

    // a stalled master simply leaves its read slots unissued
    assign tx_ready = ~stall;

    always @(posedge clk_sys)
    begin
        if (!rst && tx_valid && tx_ready)
        begin
            got_q.push_back(tx_byte);
        end
    end

    // byte held until the edge at which rx_ready is seen high
    task automatic send_byte(input logic [7:0] b);
        int n;
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_byte  <= b;
        #1;
        n = 0;
        while (rx_ready !== 1'b1 && n < 200)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        // released slot: inverse of the last byte, never a stale copy
        rx_byte  <= ~b;
    endtask
endmodule

// ### eprom_write_command_sequencer_tb.sv
// self-checking bench for the eprom write command sequencer
// assumes the slot master model stands in for the bus master
`include "eprom_write_defines.svh"

module eprom_write_command_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        stall = 1'b0;
    logic [2:0]  pulses = 3'h0;
    logic        rx_valid, rx_ready, tx_valid, tx_ready, prog_armed, busy;
    logic [7:0]  rx_byte, tx_byte;
    logic [7:0]  emem [2048];
    logic [7:0]  smem [64];
    logic [15:0] adr, crc;
    int          failures = 0;
    int          n_tests = 0;

    always #10 clk_sys = ~clk_sys;

    eprom_write_command_sequencer dut (
        .clk_sys(clk_sys), .rst(rst), .bus_reset(pulses[0]),
        .ext_read_done(pulses[2]), .prog_pulse(pulses[1]),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
        .prog_armed(prog_armed), .busy(busy));

    slot_master_model master (
        .clk_sys(clk_sys), .rst(rst), .stall(stall), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
            r = (r >> 1) ^ ((r[0] ^ b[i]) ? `CRC_POLY_REFL : 16'h0000);
        return r;
    endfunction

    // one-cycle strobe: bit0 bus reset, bit1 programming, bit2 read end
    task automatic strobe(input logic [2:0] m);
        @(posedge clk_sys);
        pulses <= m;
        @(posedge clk_sys);
        pulses <= 3'h0;
    endtask

    task automatic pop(output logic [7:0] b);
        int n;
        n = 0;
        while (master.got_q.size() == 0 && n < 300)
        begin
            @(posedge clk_sys);
            n++;
        end
        b = (master.got_q.size() > 0) ? master.got_q.pop_front() : 8'hxx;
    endtask

    task automatic abort();
        strobe(3'h1);
        @(posedge clk_sys);
        #1;
        check("idle after abort", 16'h0001, {14'h0000, busy, rx_ready});
        master.got_q.delete();
    endtask

    task automatic start(input logic [7:0] cmd, input logic [15:0] a);
        adr = a & `ADDR_KEEP_MASK;
        master.send_byte(cmd);
        master.send_byte(a[7:0]);
        master.send_byte(a[15:8]);
        // crc covers the truncated address, not the one sent
        crc = crc8(crc8(crc8(`CRC_CLEAR, cmd), adr[7:0]), adr[15:8]);
    endtask

    // data byte, crc echo unless speed, pulse, verify, increment
    task automatic wr_byte(input logic [7:0] d, input bit spd, input bit st);
        logic [15:0] c;
        logic [7:0]  b;
        logic [7:0]  m;
        int          n;
        master.send_byte(d);
        c = ~crc8(crc, d);
        if (!spd)
        begin
            stall <= 1'b1;
            repeat (8) @(posedge clk_sys);
            #1;
            check("crc held in stall", 16'h0001, {15'h0000, tx_valid});
            @(posedge clk_sys);
            stall <= 1'b0;
            pop(b);
            check("crc low", {8'h00, c[7:0]}, {8'h00, b});
            pop(b);
            check("crc high", {8'h00, c[15:8]}, {8'h00, b});
        end
        n = 0;
        while (prog_armed !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("armed, busy, nothing sent", 16'h0007,
              {13'h0000, busy, prog_armed, master.got_q.size() == 0});
        // the master pulses on its own judgement of the crc
        strobe(3'h2);
        if (st)
            smem[adr[5:0]] &= d;
        else
            emem[adr[10:0]] &= d;
        m = st ? smem[adr[5:0]] : emem[adr[10:0]];
        pop(b);
        check("verify byte", {8'h00, m}, {8'h00, b});
        adr = (adr + `ADDR_STEP) & `ADDR_KEEP_MASK;
        crc = adr;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // every code, address above the top, runs across the wrap points except the speed data run
    task automatic s_modes();
        logic [7:0] cmds [4];
        cmds = '{`CMD_WRITE_DATA, `CMD_SPEED_DATA, `CMD_WRITE_STAT, `CMD_SPEED_STAT};
        for (int k = 0; k < 4; k++)
        begin
            start(cmds[k], 16'(16'hFFFE - 16'h0100 * k));
            for (int j = 0; j < 3; j++)
                wr_byte(8'hC3 ^ {k[3:0], j[3:0]}, k[0], k[1]);
            abort();
        end
    endtask

    // reprogramming a byte can only clear further bits
    task automatic s_reprogram();
        start(`CMD_WRITE_DATA, 16'h0123);
        wr_byte(8'hF0, 1'b0, 1'b0);
        abort();
        start(`CMD_WRITE_DATA, 16'h0123);
        wr_byte(8'h3C, 1'b0, 1'b0);
        abort();
    endtask

    // aborts inside the address phase and inside the crc echo
    task automatic s_abort();
        master.send_byte(`CMD_WRITE_DATA);
        master.send_byte(8'h40);
        abort();
        start(`CMD_WRITE_STAT, 16'h0007);
        master.send_byte(8'h00);
        abort();
        start(`CMD_WRITE_STAT, 16'h0007);
        wr_byte(8'hFE, 1'b0, 1'b1);
        abort();
    endtask

    // after the last page crc only ones come back, even across a stall
    task automatic s_tail();
        logic [7:0] b;
        master.send_byte(8'hA5);
        strobe(3'h4);
        for (int i = 0; i < 4; i++)
        begin
            pop(b);
            check("tail fill", 16'h00FF, {8'h00, b});
            stall <= ~stall;
            repeat (3) @(posedge clk_sys);
        end
        stall <= 1'b0;
        abort();
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic test_done();
        if (failures == 0 && n_tests > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial
    begin
        foreach (emem[i]) emem[i] = `ERASED_BYTE;
        foreach (smem[i]) smem[i] = `ERASED_BYTE;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        s_modes();
        s_reprogram();
        s_abort();
        s_tail();
        test_done();
    end

    // the whole run takes a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        test_done();
    end
endmodule
